/* File: hw/sign_and_skip_exec.sv */
// Overview of operation
// - Sign sets the chosen accumulator to 0x000001 if non-negative, else to 0xffffff.
// - A zero accumulator counts as positive and gives plus one.
// - Sign reads two's complement, is two units long, takes two cycles, touches only sign and zero flags.
// - Plain skip always jumps over the lengths of the next 0 to 3 instructions.
// - Every skip is one unit long and takes one cycle plus one per skipped instruction.
// - Skip on bit clear skips when the indexed accumulator bit is 0.
// - Skip on bit set skips when the indexed accumulator bit is 1.
// - Skip on carry clear skips only when carry is 0.
// - Skip on carry set skips only when carry is 1.
// - Skip on zero skips when the non-zero flag is 0.
// - Skip on non-zero skips when the non-zero flag is 1.
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`include "exec_consts.svh"
module sign_and_skip_exec (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [`DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [`DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    sign_and_skip_pkg::state_t state_reg;
    sign_and_skip_pkg::acc_t acc_reg [4];
    logic [`WORD_W-1:0] prog_mem [`MEM_DEPTH];
    logic [`PC_W-1:0] pc_reg;
    logic [`PC_W-1:0] prog_addr_reg;
    logic carry_reg, nonzero_reg, sign_reg, ovr_reg;
    logic [1:0] skip_left_reg;
    logic [7:0] cycles_reg;
    logic step_reg;
    logic aw_have_reg, w_have_reg;
    logic [`ADDR_W-1:0] aw_addr_reg;
    logic [`DATA_W-1:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic do_write, busy, bus_wr, is_sign, is_skip, take, bit_val;
    logic [5:0] wr_idx;
    logic [`DATA_W-1:0] wr_val;
    sign_and_skip_pkg::acc_t shifted;
    logic [`DATA_W-1:0] rd_next;

    exec_if ex();
    insn_decode u_dec (.bus(ex));
    sign_unit u_sgn (.bus(ex));

    assign ex.word = prog_mem[pc_reg];
    assign ex.operand = acc_reg[ex.acc_sel];

    ////////////////////////////////////////////////////////////////////////
    function automatic logic addr_hit(input logic [5:0] idx);
        addr_hit = (idx <= `OFS_CYCLES);
    endfunction: addr_hit

    function automatic logic [`DATA_W-1:0] merge(input logic [`DATA_W-1:0] old,
            input logic [`DATA_W-1:0] val, input logic [3:0] strb);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merge[i*8 +: 8] = val[i*8 +: 8];
            end
        end
    endfunction: merge

    ////////////////////////////////////////////////////////////////////////
    // Condition evaluation
    assign is_sign = (ex.op == `OP_SIGN);
    assign is_skip = (ex.op >= `OP_SKIP) && (ex.op <= `OP_SKIP_NONZERO);
    // Shift keeps an index above 23 from reading past the word: it tests as 0
    assign shifted = ex.operand >> ex.bit_idx;
    assign bit_val = shifted[0];

    always_comb begin
        case (ex.op)
            `OP_SKIP: take = 1'b1;
            `OP_SKIP_BIT_CLR: take = !bit_val;
            `OP_SKIP_BIT_SET: take = bit_val;
            `OP_SKIP_CARRY_CLR: take = !carry_reg;
            `OP_SKIP_CARRY_SET: take = carry_reg;
            `OP_SKIP_ZERO: take = !nonzero_reg;
            `OP_SKIP_NONZERO: take = nonzero_reg;
            default: take = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel
    assign busy = (state_reg != sign_and_skip_pkg::ST_IDLE) || step_reg;
    assign do_write = aw_have_reg && w_have_reg && !bvalid;
    assign wr_idx = aw_addr_reg[7:2];
    // Software may not disturb state while an instruction runs
    assign bus_wr = do_write && !busy;
    assign wr_val = w_data_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            aw_have_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            aw_have_reg <= 1'b1;
            aw_addr_reg <= awaddr;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
            aw_have_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'b1;
            w_have_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            w_have_reg <= 1'b1;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
        end else if (bvalid && bready) begin
            wready <= 1'b1;
            w_have_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= addr_hit(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_reg <= 1'b0;
        end else begin
            step_reg <= bus_wr && (wr_idx == `OFS_CTRL) && w_strb_reg[0] && wr_val[`CTRL_STEP];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= sign_and_skip_pkg::ST_IDLE;
        end else begin
            case (state_reg)
                sign_and_skip_pkg::ST_IDLE: begin
                    if (step_reg) begin
                        state_reg <= sign_and_skip_pkg::ST_EXEC;
                    end
                end
                sign_and_skip_pkg::ST_EXEC: begin
                    if (is_sign) begin
                        state_reg <= sign_and_skip_pkg::ST_SIGN2;
                    end else if (is_skip && take && ex.count != 2'h0) begin
                        state_reg <= sign_and_skip_pkg::ST_SKIP;
                    end else begin
                        state_reg <= sign_and_skip_pkg::ST_IDLE;
                    end
                end
                sign_and_skip_pkg::ST_SIGN2: state_reg <= sign_and_skip_pkg::ST_IDLE;
                sign_and_skip_pkg::ST_SKIP: begin
                    if (skip_left_reg == 2'h1) begin
                        state_reg <= sign_and_skip_pkg::ST_IDLE;
                    end
                end
                default: state_reg <= sign_and_skip_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            skip_left_reg <= 2'h0;
        end else if (state_reg == sign_and_skip_pkg::ST_EXEC) begin
            skip_left_reg <= (is_skip && take) ? ex.count : 2'h0;
        end else if (state_reg == sign_and_skip_pkg::ST_SKIP) begin
            skip_left_reg <= skip_left_reg - 2'h1;
        end
    end

    // Skipped instructions are walked one per cycle, so cost tracks the count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_reg <= 6'h00;
        end else if (state_reg == sign_and_skip_pkg::ST_EXEC
                || state_reg == sign_and_skip_pkg::ST_SKIP) begin
            pc_reg <= pc_reg + {{(`PC_W-2){1'b0}}, ex.len};
        end else if (bus_wr && wr_idx == `OFS_PC && w_strb_reg[0]) begin
            pc_reg <= wr_val[`PC_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cycles_reg <= 8'h00;
        end else if (step_reg) begin
            cycles_reg <= 8'h00;
        end else if (state_reg != sign_and_skip_pkg::ST_IDLE) begin
            cycles_reg <= cycles_reg + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Architectural state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 4; i++) begin
                acc_reg[i] <= 24'h000000;
            end
        end else if (state_reg == sign_and_skip_pkg::ST_EXEC && is_sign) begin
            acc_reg[ex.acc_sel] <= ex.result;
        end else if (bus_wr && wr_idx >= `OFS_ACC_X && wr_idx <= `OFS_ACC_R) begin
            acc_reg[wr_idx[1:0]] <= sign_and_skip_pkg::acc_t'(merge(
                {8'h00, acc_reg[wr_idx[1:0]]}, wr_val, w_strb_reg));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            carry_reg <= 1'b0;
            nonzero_reg <= 1'b0;
            sign_reg <= 1'b0;
            ovr_reg <= 1'b0;
        end else if (state_reg == sign_and_skip_pkg::ST_EXEC && is_sign) begin
            sign_reg <= ex.neg;
            nonzero_reg <= 1'b1;
        end else if (bus_wr && wr_idx == `OFS_FLAGS && w_strb_reg[0]) begin
            carry_reg <= wr_val[`FLAG_CARRY];
            nonzero_reg <= wr_val[`FLAG_NZ];
            sign_reg <= wr_val[`FLAG_SIGN];
            ovr_reg <= wr_val[`FLAG_OVR];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prog_addr_reg <= 6'h00;
        end else if (bus_wr && wr_idx == `OFS_PROG_ADDR && w_strb_reg[0]) begin
            prog_addr_reg <= wr_val[`PC_W-1:0];
        end else if (bus_wr && wr_idx == `OFS_PROG_DATA) begin
            prog_addr_reg <= prog_addr_reg + 6'h01;
        end
    end

    // Program store has no reset: software loads it before stepping
    always_ff @(posedge aclk) begin
        if (bus_wr && wr_idx == `OFS_PROG_DATA) begin
            prog_mem[prog_addr_reg] <= `WORD_W'(merge({16'h0000, prog_mem[prog_addr_reg]},
                wr_val, w_strb_reg));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    always_comb begin
        rd_next = 32'h00000000;
        case (araddr[7:2])
            `OFS_STATUS: rd_next = {29'h0, skip_left_reg, busy};
            `OFS_PC: rd_next = {26'h0, pc_reg};
            `OFS_FLAGS: rd_next = {28'h0, ovr_reg, sign_reg, nonzero_reg, carry_reg};
            `OFS_ACC_X, `OFS_ACC_Y, `OFS_ACC_Z, `OFS_ACC_R:
                rd_next = {8'h00, acc_reg[araddr[3:2]]};
            `OFS_PROG_ADDR: rd_next = {26'h0, prog_addr_reg};
            `OFS_PROG_DATA: rd_next = {16'h0000, prog_mem[prog_addr_reg]};
            `OFS_CYCLES: rd_next = {24'h000000, cycles_reg};
            default: rd_next = 32'h00000000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_next;
            rresp <= addr_hit(araddr[7:2]) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic in_exec;
    assign in_exec = (state_reg == sign_and_skip_pkg::ST_EXEC);

    chk_sign_plus_one: assert property (
        in_exec && is_sign && !ex.operand[`ACC_MSB]
        |=> acc_reg[$past(ex.acc_sel)] == `SIGN_POS)
        else $error("sign of non-negative value not plus one");
    chk_sign_minus_one: assert property (
        in_exec && is_sign && ex.operand[`ACC_MSB]
        |=> acc_reg[$past(ex.acc_sel)] == `SIGN_NEG)
        else $error("sign of negative value not minus one");
    chk_sign_two_cycles: assert property (
        in_exec && is_sign |=> state_reg == sign_and_skip_pkg::ST_SIGN2
        ##1 state_reg == sign_and_skip_pkg::ST_IDLE && cycles_reg == 8'h02)
        else $error("sign did not take two cycles");
    chk_sign_flags: assert property (
        in_exec && is_sign |=> nonzero_reg && sign_reg == $past(ex.neg)
        && $stable(carry_reg) && $stable(ovr_reg) && pc_reg == $past(pc_reg) + 6'h02)
        else $error("sign flags or length wrong");
    chk_skip_walk: assert property (
        state_reg == sign_and_skip_pkg::ST_SKIP
        |=> pc_reg == $past(pc_reg) + {4'h0, $past(ex.len)})
        else $error("skip did not pass one instruction length");
    chk_skip_cycles: assert property (
        in_exec && is_skip && take && ex.count == 2'h3 |=> pc_reg == $past(pc_reg) + 6'h01
        ##0 (state_reg == sign_and_skip_pkg::ST_SKIP) [*3]
        ##1 state_reg == sign_and_skip_pkg::ST_IDLE && cycles_reg == 8'h04)
        else $error("skip of three took wrong cycles");
    chk_bit_clear: assert property (
        in_exec && ex.op == `OP_SKIP_BIT_CLR && ex.count != 2'h0
        |=> (state_reg == sign_and_skip_pkg::ST_SKIP) == !$past(shifted[0]))
        else $error("bit clear skip decision wrong");
    chk_bit_set: assert property (
        in_exec && ex.op == `OP_SKIP_BIT_SET && ex.count != 2'h0
        |=> (state_reg == sign_and_skip_pkg::ST_SKIP) == $past(shifted[0]))
        else $error("bit set skip decision wrong");
    chk_carry_clear: assert property (
        in_exec && ex.op == `OP_SKIP_CARRY_CLR && ex.count != 2'h0
        |=> (state_reg == sign_and_skip_pkg::ST_SKIP) == !carry_reg)
        else $error("carry clear skip decision wrong");
    chk_carry_set: assert property (
        in_exec && ex.op == `OP_SKIP_CARRY_SET && ex.count != 2'h0
        |=> (state_reg == sign_and_skip_pkg::ST_SKIP) == carry_reg)
        else $error("carry set skip decision wrong");
    chk_zero_skip: assert property (
        in_exec && ex.op == `OP_SKIP_ZERO && ex.count != 2'h0
        |=> (state_reg == sign_and_skip_pkg::ST_SKIP) == !nonzero_reg)
        else $error("zero skip decision wrong");
    chk_nonzero_skip: assert property (
        in_exec && ex.op == `OP_SKIP_NONZERO && ex.count != 2'h0
        |=> (state_reg == sign_and_skip_pkg::ST_SKIP) == nonzero_reg)
        else $error("non-zero skip decision wrong");
    chk_skip_quiet: assert property (
        (in_exec && is_skip) || state_reg == sign_and_skip_pkg::ST_SKIP
        |=> $stable(carry_reg) && $stable(nonzero_reg) && $stable(sign_reg)
        && $stable(ovr_reg)
        && $stable(acc_reg[0]) && $stable(acc_reg[1]) && $stable(acc_reg[2])
        && $stable(acc_reg[3]))
        else $error("skip changed flags or accumulators");

    cov_sign_neg: cover property (in_exec && is_sign && ex.neg);
    cov_skip_three: cover property (in_exec && ex.op == `OP_SKIP && ex.count == 2'h3);
    cov_bit_taken: cover property (in_exec && ex.op == `OP_SKIP_BIT_SET && take);
    cov_skip_not_taken: cover property (in_exec && is_skip && !take);
endmodule: sign_and_skip_exec

/* File: hw/exec_consts.svh */
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH

`define ACC_W 24
`define ACC_MSB 23
`define PC_W 6
`define MEM_DEPTH 64
`define WORD_W 16
`define ADDR_W 8
`define DATA_W 32

// Program word fields
`define F_OP 15:12
`define F_ACC 11:10
`define F_BIT 9:5
`define F_CNT 1:0

// Opcodes
`define OP_SIGN 4'h1
`define OP_SKIP 4'h2
`define OP_SKIP_BIT_CLR 4'h3
`define OP_SKIP_BIT_SET 4'h4
`define OP_SKIP_CARRY_CLR 4'h5
`define OP_SKIP_CARRY_SET 4'h6
`define OP_SKIP_ZERO 4'h7
`define OP_SKIP_NONZERO 4'h8
`define OP_WIDE2 4'he
`define OP_WIDE3 4'hf

`define LEN_1 2'h1
`define LEN_2 2'h2
`define LEN_3 2'h3

`define SIGN_POS 24'h000001
`define SIGN_NEG 24'hffffff

// Register word offsets (byte address is offset times 4)
`define OFS_CTRL 6'h00
`define OFS_STATUS 6'h01
`define OFS_PC 6'h02
`define OFS_FLAGS 6'h03
`define OFS_ACC_X 6'h04
`define OFS_ACC_Y 6'h05
`define OFS_ACC_Z 6'h06
`define OFS_ACC_R 6'h07
`define OFS_PROG_ADDR 6'h08
`define OFS_PROG_DATA 6'h09
`define OFS_CYCLES 6'h0a

`define FLAG_CARRY 0
`define FLAG_NZ 1
`define FLAG_SIGN 2
`define FLAG_OVR 3
`define CTRL_STEP 0
`define STATUS_BUSY 0

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* File: hw/sign_and_skip_pkg.sv */
package sign_and_skip_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SIGN2, ST_SKIP} state_t;
    typedef logic [23:0] acc_t;
    typedef logic [1:0] acc_sel_t;
endpackage: sign_and_skip_pkg

/* File: hw/exec_if.sv */
`include "exec_consts.svh"
interface exec_if;
    logic [`WORD_W-1:0] word;
    logic [3:0] op;
    logic [1:0] len;
    sign_and_skip_pkg::acc_sel_t acc_sel;
    logic [4:0] bit_idx;
    logic [1:0] count;
    sign_and_skip_pkg::acc_t operand;
    sign_and_skip_pkg::acc_t result;
    logic neg;
    modport dec(input word, output op, len, acc_sel, bit_idx, count);
    modport sgn(input operand, output result, neg);
    modport core(output word, operand, input op, len, acc_sel, bit_idx, count, result, neg);
endinterface: exec_if

/* File: hw/insn_decode.sv */
`include "exec_consts.svh"
module insn_decode (
    exec_if.dec bus
);
    assign bus.op = bus.word[`F_OP];
    assign bus.acc_sel = bus.word[`F_ACC];
    assign bus.bit_idx = bus.word[`F_BIT];
    assign bus.count = bus.word[`F_CNT];

    // Length in program units; skip-type opcodes fall to one unit
    always_comb begin
        case (bus.word[`F_OP])
            `OP_SIGN: bus.len = `LEN_2;
            `OP_WIDE2: bus.len = `LEN_2;
            `OP_WIDE3: bus.len = `LEN_3;
            default: bus.len = `LEN_1;
        endcase
    end
endmodule: insn_decode

/* File: hw/sign_unit.sv */
`include "exec_consts.svh"
module sign_unit (
    exec_if.sgn bus
);
    // Two's complement: only the top bit decides, zero counts as positive
    assign bus.neg = bus.operand[`ACC_MSB];
    assign bus.result = bus.neg ? `SIGN_NEG : `SIGN_POS;
endmodule: sign_unit

/* File: verification/tb_top.sv */
`include "exec_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [3:0] op;
        logic [1:0] sel;
        logic [4:0] bt;
        logic [1:0] cnt;
        logic [23:0] acc;
        logic [3:0] fl;
        logic [5:0] pc;
        logic [3:0] cyc;
        logic [23:0] racc;
        logic [3:0] rfl;
    } row_t;

    logic aclk;
    logic aresetn;
    logic [7:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int err_total;
    int samples_checked;
    row_t rows[18];
    logic [15:0] tail[7];

    sign_and_skip_exec DUT (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("Comparisons: %0d, mismatches: %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask: wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask: chk

    task automatic stall();
        err_total++;
        $display("Error at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
        wrap_up();
    endtask: stall

    function automatic logic [7:0] ra(input logic [5:0] idx);
        return {idx, 2'b00};
    endfunction: ra

    // Payloads held until their own ready; response ready raised from the start
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er = `RESP_OKAY);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                done = 1'b1;
                bready <= 1'b0;
                chk(32'(bresp), 32'(er));
            end
            if (n > 40) stall();
        end
    endtask: axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          input logic [1:0] er = `RESP_OKAY);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                done = 1'b1;
                d = rdata;
                rready <= 1'b0;
                chk(32'(rresp), 32'(er));
            end
            if (n > 40) stall();
        end
    endtask: axi_rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] er = `RESP_OKAY);
        logic [31:0] d;
        axi_rd(a, d, er);
        chk(d, exp);
    endtask: rchk

    // Busy is polled, never timed: skip count sets the duration
    task automatic step();
        logic [31:0] d;
        int n;
        axi_wr(ra(`OFS_CTRL), 32'h00000001);
        d = 32'h00000001;
        n = 0;
        while (d[`STATUS_BUSY] !== 1'b0) begin
            axi_rd(ra(`OFS_STATUS), d);
            n++;
            if (n > 20) stall();
        end
    endtask: step

    task automatic run_row(input row_t r);
        axi_wr(ra(`OFS_PROG_ADDR), 32'h00000000);
        axi_wr(ra(`OFS_PROG_DATA), 32'({r.op, r.sel, r.bt, 3'b000, r.cnt}));
        axi_wr(ra(`OFS_PC), 32'h00000000);
        axi_wr(ra(`OFS_FLAGS), 32'(r.fl));
        axi_wr(ra(`OFS_ACC_X + 6'(r.sel)), 32'(r.acc));
        step();
        rchk(ra(`OFS_PC), 32'(r.pc));
        rchk(ra(`OFS_CYCLES), 32'(r.cyc));
        rchk(ra(`OFS_ACC_X + 6'(r.sel)), 32'(r.racc));
        rchk(ra(`OFS_FLAGS), 32'(r.rfl));
    endtask: run_row

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        err_total = 0;
        samples_checked = 0;
        aresetn = 1'b0;
        {awaddr, araddr, awprot, arprot, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hf;
        // Taken skips land on 3, 6, 7: lengths 2, 3, 1 follow slot 0
        tail = '{16'he000, 16'h0000, 16'hf000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
        rows[0] = '{`OP_SIGN, 2'd0, 5'd0, 2'd0, 24'h7fffff, 4'h0, 6'd2, 4'd2, 24'h000001, 4'h2};
        rows[1] = '{`OP_SIGN, 2'd1, 5'd0, 2'd0, 24'h000000, 4'h9, 6'd2, 4'd2, 24'h000001, 4'hb};
        rows[2] = '{`OP_SIGN, 2'd2, 5'd0, 2'd0, 24'h800000, 4'h0, 6'd2, 4'd2, 24'hffffff, 4'h6};
        rows[3] = '{`OP_SIGN, 2'd3, 5'd0, 2'd0, 24'hffffff, 4'h1, 6'd2, 4'd2, 24'hffffff, 4'h7};
        rows[4] = '{`OP_SKIP, 2'd0, 5'd0, 2'd1, 24'h000abc, 4'h0, 6'd3, 4'd2, 24'h000abc, 4'h0};
        rows[5] = '{`OP_SKIP, 2'd0, 5'd0, 2'd3, 24'h000000, 4'hf, 6'd7, 4'd4, 24'h000000, 4'hf};
        rows[6] = '{`OP_SKIP_BIT_CLR, 2'd1, 5'd23, 2'd2, 24'h7fffff, 4'h0, 6'd6, 4'd3, 24'h7fffff, 4'h0};
        rows[7] = '{`OP_SKIP_BIT_CLR, 2'd1, 5'd0, 2'd2, 24'h000001, 4'h0, 6'd1, 4'd1, 24'h000001, 4'h0};
        rows[8] = '{`OP_SKIP_BIT_SET, 2'd3, 5'd5, 2'd1, 24'h000020, 4'h0, 6'd3, 4'd2, 24'h000020, 4'h0};
        rows[9] = '{`OP_SKIP_BIT_SET, 2'd3, 5'd5, 2'd1, 24'hffffdf, 4'h0, 6'd1, 4'd1, 24'hffffdf, 4'h0};
        rows[10] = '{`OP_SKIP_CARRY_CLR, 2'd0, 5'd0, 2'd3, 24'h0, 4'h0, 6'd7, 4'd4, 24'h0, 4'h0};
        rows[11] = '{`OP_SKIP_CARRY_CLR, 2'd0, 5'd0, 2'd3, 24'h0, 4'h1, 6'd1, 4'd1, 24'h0, 4'h1};
        rows[12] = '{`OP_SKIP_CARRY_SET, 2'd0, 5'd0, 2'd2, 24'h0, 4'h1, 6'd6, 4'd3, 24'h0, 4'h1};
        rows[13] = '{`OP_SKIP_CARRY_SET, 2'd0, 5'd0, 2'd2, 24'h0, 4'he, 6'd1, 4'd1, 24'h0, 4'he};
        rows[14] = '{`OP_SKIP_ZERO, 2'd0, 5'd0, 2'd1, 24'h0, 4'h0, 6'd3, 4'd2, 24'h0, 4'h0};
        rows[15] = '{`OP_SKIP_ZERO, 2'd0, 5'd0, 2'd1, 24'h0, 4'h2, 6'd1, 4'd1, 24'h0, 4'h2};
        rows[16] = '{`OP_SKIP_NONZERO, 2'd0, 5'd0, 2'd2, 24'h0, 4'h2, 6'd6, 4'd3, 24'h0, 4'h2};
        rows[17] = '{`OP_SKIP_NONZERO, 2'd0, 5'd0, 2'd2, 24'h0, 4'hd, 6'd1, 4'd1, 24'h0, 4'hd};
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(ra(`OFS_PC), 32'h00000000);
        rchk(ra(`OFS_FLAGS), 32'h00000000);
        rchk(ra(`OFS_ACC_X), 32'h00000000);
        // Memory is not cleared by reset, so the tail is loaded once
        axi_wr(ra(`OFS_PROG_ADDR), 32'h00000001);
        foreach (tail[i]) axi_wr(ra(`OFS_PROG_DATA), 32'(tail[i]));
        foreach (rows[i]) run_row(rows[i]);
        // Last row was a refused skip: nothing may be left pending
        rchk(ra(`OFS_STATUS), 32'h00000000);
        // A sign sitting in the skipped slot must leave x alone
        axi_wr(ra(`OFS_PROG_ADDR), 32'h00000001);
        axi_wr(ra(`OFS_PROG_DATA), 32'({`OP_SIGN, 12'h000}));
        run_row('{`OP_SKIP, 2'd0, 5'd0, 2'd1, 24'h000500, 4'h0, 6'd3, 4'd2, 24'h000500, 4'h0});
        // Unmapped place and read-only status
        axi_wr(8'h2c, 32'hffffffff, `RESP_SLVERR);
        rchk(8'h2c, 32'h00000000, `RESP_SLVERR);
        axi_wr(ra(`OFS_STATUS), 32'hffffffff);
        rchk(ra(`OFS_STATUS), 32'h00000000);
        // Second reset in mid-run
        axi_wr(ra(`OFS_PC), 32'h00000005);
        rchk(ra(`OFS_PC), 32'h00000005);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(ra(`OFS_PC), 32'h00000000);
        rchk(ra(`OFS_ACC_X), 32'h00000000);
        wrap_up();
    end
endmodule: tb_top
